// ===== tcc_pkg.sv
// Shared constants and types for the timer counter core
package tcc_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses on the AXI4-Lite slave
  // ----------------------------------------------------------------
  localparam logic [7:0] TCC_OFF_TSC  = 8'h00;
  localparam logic [7:0] TCC_OFF_CNTH = 8'h04;
  localparam logic [7:0] TCC_OFF_CNTL = 8'h08;
  localparam logic [7:0] TCC_OFF_MODH = 8'h0c;
  localparam logic [7:0] TCC_OFF_MODL = 8'h10;
  localparam logic [7:0] TCC_OFF_CSC  = 8'h14;
  localparam logic [7:0] TCC_OFF_CVAL = 8'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TCC_TSC_OVF  = 7;
  localparam int TCC_TSC_IE   = 6;
  localparam int TCC_TSC_CPWM = 5;
  localparam int TCC_TSC_CLK  = 3;
  localparam int TCC_TSC_PS   = 0;
  localparam int TCC_CSC_FLAG = 7;
  localparam int TCC_CSC_IE   = 6;
  localparam int TCC_CSC_MODE = 4;
  localparam int TCC_CSC_ELS  = 2;
  // ----------------------------------------------------------------
  // Values after reset, limits and widths
  // ----------------------------------------------------------------
  localparam logic [15:0] TCC_CNT_RST = 16'h0000;
  localparam logic [15:0] TCC_MOD_RST = 16'h0000;
  localparam logic [15:0] TCC_FULL    = 16'hffff;
  localparam int          TCC_PRE_W   = 7;
  localparam logic [1:0]  TCC_OKAY    = 2'b00;
  localparam logic [1:0]  TCC_SLVERR  = 2'b10;
  // Clock source codes
  typedef enum logic [1:0] {
    TCC_SRC_OFF   = 2'b00,
    TCC_SRC_BUS   = 2'b01,
    TCC_SRC_FIXED = 2'b10,
    TCC_SRC_EXT   = 2'b11
  } tcc_src_t;
  // Counting direction
  typedef enum logic [0:0] {
    TCC_UP   = 1'b0,
    TCC_DOWN = 1'b1
  } tcc_dir_t;
endpackage

// ===== tcc_tick_if.sv
// Carrier between the core and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface tcc_tick_if;
  tcc_pkg::tcc_src_t src;
  logic [2:0]        ps;
  logic              tick;
  modport gen (input src, input ps, output tick);
  modport core (output src, output ps, input tick);
endinterface
`default_nettype wire

// ===== tcc_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module tcc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tcc_sync_t;
  tcc_sync_t s_q;
  tcc_sync_t s_d;
  if (W < 1) begin : g_chk
    $error("tcc_sync2: W must be at least 1");
  end
  // First stage feeds only the second stage
  always_comb begin
    s_d    = s_q;
    s_d.s1 = d_i;
    s_d.s2 = s_q.s1;
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign q_o = s_q.s2;
endmodule
`default_nettype wire

// ===== tcc_prescaler.sv
// Clock source selection and power-of-two prescaler
`timescale 1ns/10ps
`default_nettype none
module tcc_prescaler (
  input  wire logic  clk_i,
  input  wire logic  reset_i,
  input  wire logic  ext_s_i,
  input  wire logic  fix_s_i,
  tcc_tick_if.gen    tk
);
  import tcc_pkg::*;
  typedef struct packed {
    logic                 ext;
    logic                 fix;
    logic [TCC_PRE_W-1:0] pre;
  } tcc_pre_t;
  tcc_pre_t             s_q;
  tcc_pre_t             s_d;
  logic                 in_tick;
  logic [TCC_PRE_W-1:0] mask;
  // Rising edges of the synced slow sources act as input ticks
  always_comb begin
    s_d     = s_q;
    s_d.ext = ext_s_i;
    s_d.fix = fix_s_i;
    mask    = ~({TCC_PRE_W{1'b1}} << tk.ps);
    case (tk.src)
      TCC_SRC_BUS:   in_tick = 1'b1;
      TCC_SRC_FIXED: in_tick = fix_s_i & ~s_q.fix;
      TCC_SRC_EXT:   in_tick = ext_s_i & ~s_q.ext;
      default:       in_tick = 1'b0;
    endcase
    // Divide by two to the power of the select code
    tk.tick = in_tick && ((s_q.pre & mask) == mask);
    if (tk.src == TCC_SRC_OFF) begin
      s_d.pre = '0;
    end else if (in_tick) begin
      s_d.pre = s_q.pre + 7'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ===== tcc_core.sv
// Timer counter core with one channel and an AXI4-Lite register slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Source code picks off, bus, fixed, external
// - Prescaler divides by two to the code
// - Counter byte read freezes both bytes
// - Latch released by reset, counter, status writes
// - Reset clears the counter
// - Debug mode freezes counter and latch
// - At modulo wrap or turn, set overflow
// - One modulo byte written inhibits overflow
// - Reset modulo zero means free running
// - Capture edge sets channel flag
// - Compare match sets channel flag
// - Center mode match sets flag both ways
// - Flag with enable requests channel interrupt
// - Flag clears by read-set then write zero
// - Reset clears channel flag and enable
// - Slow clocks synchronised before selection
// - Center mode overflow on leaving modulo
// - Overflow flag clears by read then zero
// - Center select picks up or up/down
module tcc_core (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        bgnd_active_i,
  input  wire logic        ext_clk_i,
  input  wire logic        fixed_clk_i,
  input  wire logic        chan_pin_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [15:0]      count_o,
  output logic             match_o,
  output logic             ovf_irq_o,
  output logic             chan_irq_o
);
  import tcc_pkg::*;
  typedef struct packed {
    logic        ovf, ovf_ie, cpwm;
    tcc_src_t    src;
    logic [2:0]  ps;
    logic        ovf_arm;
    logic [15:0] cnt;
    tcc_dir_t    dir;
    logic [15:0] modv;
    logic [15:0] mod_buf;
    logic        mod_hi_pend, mod_lo_pend;
    logic [15:0] cnt_buf;
    logic        latched, wait_lo;
    logic        ch_flag, ch_ie;
    logic [1:0]  ch_mode;
    logic [1:0]  ch_els;
    logic [15:0] ch_val;
    logic        ch_arm, pin_q, match;
    logic        aw_hold;
    logic [7:0]  awaddr;
    logic        w_hold;
    logic [15:0] wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tcc_core_t;
  tcc_core_t   s_q;
  tcc_core_t   s_d;
  tcc_tick_if  tk ();
  logic [2:0]  pins_s;
  logic        ar_go, wr_go, cnt_wr, step, ovf_evt, ch_evt, pin_edge;
  logic [15:0] lim;
  // ----------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------
  // Slow clocks and the channel pin come from outside the bus clock
  tcc_sync2 #(.W(3)) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .d_i     ({chan_pin_i, fixed_clk_i, ext_clk_i}),
    .q_o     (pins_s)
  );
  tcc_prescaler u_pre (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ext_s_i (pins_s[0]),
    .fix_s_i (pins_s[1]),
    .tk      (tk)
  );
  assign tk.src = s_q.src;
  assign tk.ps  = s_q.ps;
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus effects first, then hardware events, so a set wins over a clear
  always_comb begin
    s_d      = s_q;
    ar_go    = s_axi_arvalid && !s_q.rvalid;
    wr_go    = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
    cnt_wr   = 1'b0;
    ovf_evt  = 1'b0;
    lim      = (s_q.modv == TCC_MOD_RST) ? TCC_FULL : s_q.modv;
    s_d.match = 1'b0;
    if (s_axi_bvalid && s_axi_bready) s_d.bvalid = 1'b0;
    if (s_q.rvalid && s_axi_rready) s_d.rvalid = 1'b0;
    if (s_axi_awvalid && !s_q.aw_hold) begin
      s_d.aw_hold = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_hold) begin
      s_d.w_hold = 1'b1;
      s_d.wdata  = s_axi_wdata[15:0];
      s_d.wstrb0 = s_axi_wstrb[0];
    end
    // Reads, with their side effects on the latch and clear arming
    if (ar_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = TCC_OKAY;
      s_d.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        TCC_OFF_TSC: begin
          s_d.rdata[7:0] = {s_q.ovf, s_q.ovf_ie, s_q.cpwm, s_q.src, s_q.ps};
          if (s_q.ovf) s_d.ovf_arm = 1'b1;
        end
        TCC_OFF_CNTH, TCC_OFF_CNTL: begin
          s_d.rdata[7:0] = (s_axi_araddr == TCC_OFF_CNTH) ? (s_q.latched ? s_q.cnt_buf[15:8] : s_q.cnt[15:8])
                                                          : (s_q.latched ? s_q.cnt_buf[7:0] : s_q.cnt[7:0]);
          // Re-reading the first byte keeps the latch; only the other byte frees it
          if (!bgnd_active_i && !s_q.latched) begin
            s_d.latched = 1'b1;
            s_d.cnt_buf = s_q.cnt;
            s_d.wait_lo = (s_axi_araddr == TCC_OFF_CNTH);
          end else if (!bgnd_active_i && s_q.wait_lo == (s_axi_araddr == TCC_OFF_CNTL)) begin
            s_d.latched = 1'b0;
          end
        end
        TCC_OFF_MODH: s_d.rdata[7:0] = s_q.modv[15:8];
        TCC_OFF_MODL: s_d.rdata[7:0] = s_q.modv[7:0];
        TCC_OFF_CSC: begin
          s_d.rdata[7:0] = {s_q.ch_flag, s_q.ch_ie, s_q.ch_mode, s_q.ch_els, 2'b00};
          if (s_q.ch_flag) s_d.ch_arm = 1'b1;
        end
        TCC_OFF_CVAL: s_d.rdata[15:0] = s_q.ch_val;
        default:      s_d.rresp = TCC_SLVERR;
      endcase
    end
    // Writes take effect one cycle after address and data are both held
    if (wr_go) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = TCC_OKAY;
      case (s_q.awaddr)
        TCC_OFF_TSC: if (s_q.wstrb0) begin
          s_d.ovf_ie  = s_q.wdata[TCC_TSC_IE];
          s_d.cpwm    = s_q.wdata[TCC_TSC_CPWM];
          s_d.src     = tcc_src_t'(s_q.wdata[TCC_TSC_CLK +: 2]);
          s_d.ps      = s_q.wdata[TCC_TSC_PS +: 3];
          s_d.latched = 1'b0;
          if (!s_q.wdata[TCC_TSC_OVF] && s_q.ovf_arm) s_d.ovf = 1'b0;
          s_d.ovf_arm = 1'b0;
        end
        TCC_OFF_CNTH, TCC_OFF_CNTL: if (s_q.wstrb0) begin
          cnt_wr      = 1'b1;
          s_d.cnt     = TCC_CNT_RST;
          s_d.dir     = TCC_UP;
          s_d.latched = 1'b0;
        end
        TCC_OFF_MODH: if (s_q.wstrb0) begin
          s_d.mod_buf[15:8] = s_q.wdata[7:0];
          s_d.mod_hi_pend   = 1'b1;
        end
        TCC_OFF_MODL: if (s_q.wstrb0) begin
          s_d.mod_buf[7:0] = s_q.wdata[7:0];
          s_d.mod_lo_pend  = 1'b1;
        end
        TCC_OFF_CSC: if (s_q.wstrb0) begin
          s_d.ch_ie   = s_q.wdata[TCC_CSC_IE];
          s_d.ch_mode = s_q.wdata[TCC_CSC_MODE +: 2];
          s_d.ch_els  = s_q.wdata[TCC_CSC_ELS +: 2];
          if (!s_q.wdata[TCC_CSC_FLAG] && s_q.ch_arm) s_d.ch_flag = 1'b0;
          s_d.ch_arm  = 1'b0;
        end
        TCC_OFF_CVAL: if (s_q.wstrb0) s_d.ch_val = s_q.wdata;
        default:      s_d.bresp = TCC_SLVERR;
      endcase
    end
    // Modulo takes both bytes at once, once the second byte lands
    if (s_d.mod_hi_pend && s_d.mod_lo_pend) begin
      s_d.modv        = s_d.mod_buf;
      s_d.mod_hi_pend = 1'b0;
      s_d.mod_lo_pend = 1'b0;
    end
    // Counter step on each prescaled tick, frozen in debug mode
    step = tk.tick && !bgnd_active_i && !cnt_wr;
    if (step) begin
      if (!s_q.cpwm) begin
        if (s_q.cnt == lim) begin
          s_d.cnt = TCC_CNT_RST;
          ovf_evt = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else begin
        // Turn at either end first, then step in the new direction
        if (s_q.dir == TCC_UP && s_q.cnt == lim) begin
          s_d.dir = TCC_DOWN;
          ovf_evt = 1'b1;
        end else if (s_q.dir == TCC_DOWN && s_q.cnt == TCC_CNT_RST) begin
          s_d.dir = TCC_UP;
        end
        s_d.cnt = (s_d.dir == TCC_UP) ? 16'(s_q.cnt + 16'h0001) : 16'(s_q.cnt - 16'h0001);
      end
    end
    // A half-written modulo hides the overflow; a new one restarts the clear
    if (ovf_evt && !(s_d.mod_hi_pend || s_d.mod_lo_pend)) begin
      s_d.ovf     = 1'b1;
      s_d.ovf_arm = 1'b0;
    end
    // Channel event: capture edge, or counter match in any compare mode
    s_d.pin_q = pins_s[2];
    case (s_q.ch_els)
      2'b01:   pin_edge = pins_s[2] & ~s_q.pin_q;
      2'b10:   pin_edge = ~pins_s[2] & s_q.pin_q;
      2'b11:   pin_edge = pins_s[2] ^ s_q.pin_q;
      default: pin_edge = 1'b0;
    endcase
    if (!s_q.cpwm && s_q.ch_mode == 2'b00) begin
      ch_evt = pin_edge;
      if (pin_edge) s_d.ch_val = s_q.cnt;
    end else begin
      ch_evt    = step && (s_d.cnt == s_q.ch_val);
      s_d.match = ch_evt;
    end
    if (ch_evt) begin
      s_d.ch_flag = 1'b1;
      s_d.ch_arm  = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign s_axi_awready = !s_q.aw_hold;
  assign s_axi_wready  = !s_q.w_hold;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign count_o       = s_q.cnt;
  assign match_o       = s_q.match;
  assign ovf_irq_o     = s_q.ovf & s_q.ovf_ie;
  assign chan_irq_o    = s_q.ch_flag & s_q.ch_ie;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_src_off;
    s_q.src == TCC_SRC_OFF && !wr_go |=> $stable(s_q.cnt);
  endproperty
  a_src_off: assert property (p_src_off) else $error("counter moved with no clock");
  property p_ps0_bus;
    s_q.src == TCC_SRC_BUS && s_q.ps == 3'h0 && !s_q.cpwm && s_q.modv == 16'h0000 && !bgnd_active_i && !wr_go
      |=> s_q.cnt == 16'($past(s_q.cnt) + 16'h0001);
  endproperty
  a_ps0_bus: assert property (p_ps0_bus) else $error("bus clock divide by one missed");
  property p_reset_clear;
    disable iff (1'b0) reset_i |=> s_q.cnt == 16'h0000 && s_q.modv == 16'h0000 && !s_q.ch_flag && !s_q.ch_ie;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state");
  property p_bgnd_freeze;
    bgnd_active_i && !wr_go |=> $stable(s_q.latched) && $stable(s_q.cnt);
  endproperty
  a_bgnd_freeze: assert property (p_bgnd_freeze) else $error("debug mode did not freeze");
  property p_wrap_up;
    tk.tick && !bgnd_active_i && !s_q.cpwm && s_q.modv != 16'h0000 && s_q.cnt == s_q.modv && !wr_go
      && !s_q.mod_hi_pend && !s_q.mod_lo_pend |=> s_q.cnt == 16'h0000 && s_q.ovf;
  endproperty
  a_wrap_up: assert property (p_wrap_up) else $error("modulo wrap wrong");
  property p_mod_inhibit;
    (s_q.mod_hi_pend ^ s_q.mod_lo_pend) && !s_q.ovf && !wr_go |=> !s_q.ovf;
  endproperty
  a_mod_inhibit: assert property (p_mod_inhibit) else $error("overflow during half modulo write");
  property p_center_turn;
    tk.tick && !bgnd_active_i && s_q.cpwm && s_q.dir == TCC_UP && s_q.cnt == lim && s_q.cnt != 16'h0000
      && !wr_go && !s_q.mod_hi_pend && !s_q.mod_lo_pend
      |=> s_q.dir == TCC_DOWN && s_q.ovf && s_q.cnt == 16'($past(s_q.cnt) - 16'h0001);
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center turn wrong");
  property p_flag_sticky;
    s_q.ch_flag && !wr_go |=> s_q.ch_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("channel flag cleared without write");
  property p_chan_irq;
    s_q.ch_ie && $rose(s_q.ch_flag) |-> chan_irq_o ##1 (chan_irq_o || !s_q.ch_flag || !s_q.ch_ie);
  endproperty
  a_chan_irq: assert property (p_chan_irq) else $error("channel request missing");
  property p_cnt_write;
    wr_go && s_q.wstrb0 && (s_q.awaddr == TCC_OFF_CNTH || s_q.awaddr == TCC_OFF_CNTL)
      |=> s_q.cnt == 16'h0000 && !s_q.latched;
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write did not clear");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 (s_axi_rvalid [*1]);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule
`default_nettype wire

// ===== tcc_core_bench.sv
// Self-checking bench for the timer counter core over its AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tcc_core_bench;
  import tcc_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------------------------------
  localparam int LIMIT = 20000;
  logic        clk_i = 1'b0, reset_i = 1'b1, bgnd_active_i = 1'b0;
  logic        ext_clk_i = 1'b0, fixed_clk_i = 1'b0, chan_pin_i = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lo_a;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        match_o, ovf_irq_o, chan_irq_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bresp_v, rresp_v;
  logic [15:0] count_o, snap;
  int          n_errors = 0, n_tests = 0, cyc = 0, n;

  tcc_core u_dut (.clk_i, .reset_i, .bgnd_active_i, .ext_clk_i, .fixed_clk_i, .chan_pin_i,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .count_o, .match_o, .ovf_irq_o, .chan_irq_o);

  // 40 MHz bus clock
  always #12.5 clk_i = ~clk_i;

  // Watchdog: a hung handshake ends the run as a mismatch
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks: entered just after a rising edge, leave one idle cycle
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge clk_i);
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid !== 1'b1);
    bresp_v = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rresp_v = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(nm, e, rdat[7:0])
  endtask

  // Cycles between two counter steps, measured after the next change
  task automatic step_len(output int k);
    logic [15:0] c;
    c = count_o;
    k = 0;
    while (count_o === c) @(posedge clk_i);
    c = count_o;
    while (count_o === c) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  task automatic pin(input logic v);
    chan_pin_i <= v;
    repeat (8) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    // Values after reset, unmapped place refused
    rc("tsc", TCC_OFF_TSC, 8'h00);
    rc("cnth", TCC_OFF_CNTH, 8'h00);
    rc("cntl", TCC_OFF_CNTL, 8'h00);
    rc("modh", TCC_OFF_MODH, 8'h00);
    rc("modl", TCC_OFF_MODL, 8'h00);
    rc("csc", TCC_OFF_CSC, 8'h00);
    rd(8'h1c);
    `CHK("rresp", TCC_SLVERR, rresp_v)
    wr(8'h1c, 16'h00ff);
    `CHK("bresp", TCC_SLVERR, bresp_v)
    repeat (20) @(posedge clk_i);
    `CHK("cnt_off", 16'h0000, count_o)
    // Coherent reads while free running at bus rate
    wr(TCC_OFF_TSC, 16'h0008);
    rd(TCC_OFF_CNTL);
    lo_a = rdat[7:0];
    rc("cntl_hold", TCC_OFF_CNTL, lo_a);
    rc("cntl_hold2", TCC_OFF_CNTL, lo_a);
    rd(TCC_OFF_CNTH);
    rd(TCC_OFF_CNTL);
    `CHK("relatch", 1'b1, rdat[7:0] !== lo_a)
    lo_a = rdat[7:0];
    wr(TCC_OFF_TSC, 16'h0008);
    rd(TCC_OFF_CNTL);
    `CHK("tsc_release", 1'b1, rdat[7:0] !== lo_a)
    wr(TCC_OFF_CNTH, 16'h00aa);
    rc("clr_hi", TCC_OFF_CNTH, 8'h00);
    rd(TCC_OFF_CNTL);
    `CHK("clr_lo", 1'b1, rdat[7:0] < 8'h10)
    // Background mode freezes counter and latch
    rd(TCC_OFF_CNTL);
    lo_a = rdat[7:0];
    bgnd_active_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    snap = count_o;
    repeat (20) @(posedge clk_i);
    `CHK("bgnd_cnt", snap, count_o)
    rd(TCC_OFF_CNTH);
    bgnd_active_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    rc("bgnd_latch", TCC_OFF_CNTL, lo_a);
    rd(TCC_OFF_CNTH);
    // Modulo 9, every prescale code; counter cleared first so the first wrap is near
    wr(TCC_OFF_CNTL, 16'h0000);
    wr(TCC_OFF_MODH, 16'h0000);
    wr(TCC_OFF_MODL, 16'h0009);
    for (int p = 0; p < 8; p++) begin
      wr(TCC_OFF_TSC, 16'h0008 | 16'(p));
      step_len(n);
      step_len(n);
      `CHK("prescale", 1 << p, n)
    end
    wr(TCC_OFF_TSC, 16'h0008);
    snap = 16'h0000;
    repeat (30) begin
      @(posedge clk_i);
      if (count_o > snap) snap = count_o;
    end
    `CHK("limit", 16'h0009, snap)
    // Center-aligned: stop, arm and clear the old overflow, then turn down at the limit
    wr(TCC_OFF_TSC, 16'h0000);
    rd(TCC_OFF_TSC);
    wr(TCC_OFF_TSC, 16'h0028);
    for (int i = 0; i < 40 && count_o !== 16'h0009; i++) @(posedge clk_i);
    while (count_o === 16'h0009) @(posedge clk_i);
    `CHK("center_turn", 16'h0008, count_o)
    rd(TCC_OFF_TSC);
    `CHK("ovf_center", 1'b1, rdat[7])
    // Overflow interrupt, clear needs a read that saw the flag
    wr(TCC_OFF_TSC, 16'h0048);
    for (int i = 0; i < 40 && ovf_irq_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("ovf_irq", 1'b1, ovf_irq_o)
    wr(TCC_OFF_TSC, 16'h0040);
    rc("ovf_noarm", TCC_OFF_TSC, 8'hc0);
    wr(TCC_OFF_TSC, 16'h0040);
    rc("ovf_clr", TCC_OFF_TSC, 8'h40);
    `CHK("ovf_irq_lo", 1'b0, ovf_irq_o)
    // Half-written modulo holds back the overflow
    wr(TCC_OFF_MODH, 16'h0000);
    wr(TCC_OFF_TSC, 16'h0008);
    repeat (40) @(posedge clk_i);
    rc("ovf_inhibit", TCC_OFF_TSC, 8'h08);
    rc("mod_commit", TCC_OFF_MODL, 8'h09);
    wr(TCC_OFF_CNTL, 16'h0000);
    wr(TCC_OFF_MODL, 16'h0004);
    repeat (20) @(posedge clk_i);
    rc("ovf_resume", TCC_OFF_TSC, 8'h88);
    // A write without the low byte strobe is dropped
    s_axi_wstrb <= 4'he;
    wr(TCC_OFF_MODL, 16'h0001);
    s_axi_wstrb <= 4'hf;
    rc("strb_off", TCC_OFF_MODL, 8'h04);
    // Output compare flag and channel interrupt
    wr(TCC_OFF_CVAL, 16'h0003);
    wr(TCC_OFF_CSC, 16'h0050);
    for (int i = 0; i < 40 && chan_irq_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("chan_irq", 1'b1, chan_irq_o)
    for (int i = 0; i < 40 && match_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("match", 1'b1, match_o)
    `CHK("match_cnt", 16'h0003, count_o)
    wr(TCC_OFF_TSC, 16'h0000);
    wr(TCC_OFF_CSC, 16'h00d0);
    rc("chf_keep", TCC_OFF_CSC, 8'hd0);
    wr(TCC_OFF_CSC, 16'h0010);
    rc("chf_clr", TCC_OFF_CSC, 8'h10);
    `CHK("chan_irq_lo", 1'b0, chan_irq_o)
    // Input capture edges: rising, disabled, falling
    wr(TCC_OFF_CSC, 16'h0004);
    pin(1'b1);
    rc("cap_rise", TCC_OFF_CSC, 8'h84);
    wr(TCC_OFF_CSC, 16'h0000);
    pin(1'b0);
    pin(1'b1);
    rc("cap_off", TCC_OFF_CSC, 8'h00);
    wr(TCC_OFF_CSC, 16'h0008);
    pin(1'b0);
    rc("cap_fall", TCC_OFF_CSC, 8'h88);
    // Fixed and external sources, period of eight bus cycles
    for (int s = 2; s < 4; s++) begin
      wr(TCC_OFF_CNTL, 16'h0000);
      wr(TCC_OFF_TSC, 16'(s << 3));
      repeat (4) begin
        fixed_clk_i <= (s == 2);
        ext_clk_i <= (s == 3);
        repeat (4) @(posedge clk_i);
        fixed_clk_i <= 1'b0;
        ext_clk_i <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      repeat (10) @(posedge clk_i);
      `CHK("slow_src", 16'h0004, count_o)
    end
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
